// file: acr_pkg.sv
`default_nettype none

package acr_pkg;

    // ****************************************************************
    // register offsets
    // ****************************************************************
    localparam logic [7:0] SCR_ADDR = 8'h3b;
    localparam logic [7:0] RESULT_ADDR = 8'h3c;
    localparam logic [7:0] DIVIDER_ADDR = 8'h3d;
    localparam logic [7:0] EVT_STATUS_ADDR = 8'h40;
    localparam logic [7:0] EVT_CLEAR_ADDR = 8'h41;
    localparam logic [7:0] EVT_ENABLE_ADDR = 8'h42;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int FLAG_BIT = 7;
    localparam int IRQEN_BIT = 6;
    localparam int CONT_BIT = 5;
    localparam int CHAN_LSB = 0;
    localparam int CHAN_W = 5;
    localparam int PRESCALE_LSB = 5;
    localparam int PRESCALE_W = 3;
    localparam int EVT_DONE_BIT = 0;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [7:0] SCR_RESET = 8'h1f;
    localparam logic [7:0] DIVIDER_RESET = 8'h00;
    localparam logic [7:0] RESULT_RESET = 8'h00;
    localparam logic [7:0] EVT_RESET = 8'h00;

    // ****************************************************************
    // channel codes
    // ****************************************************************
    localparam logic [4:0] CHAN_LAST_EXT = 5'h05;
    localparam logic [4:0] CHAN_RESERVED = 5'h1b;
    localparam logic [4:0] CHAN_REF_HIGH = 5'h1d;
    localparam logic [4:0] CHAN_REF_LOW = 5'h1e;
    localparam logic [4:0] CHAN_POWER_OFF = 5'h1f;

    // ****************************************************************
    // timing counts
    // ****************************************************************
    localparam logic [3:0] DIV1_LIMIT = 4'h0;
    localparam logic [3:0] DIV2_LIMIT = 4'h1;
    localparam logic [3:0] DIV4_LIMIT = 4'h3;
    localparam logic [3:0] DIV8_LIMIT = 4'h7;
    localparam logic [3:0] DIV16_LIMIT = 4'hf;
    localparam logic [3:0] SAMPLE_LAST = 4'h7;
    localparam logic [3:0] CONV_LAST = 4'hf;
    localparam logic [7:0] DAC_FIRST_TRIAL = 8'h80;

    typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_CONV} acr_state_t;

endpackage

`default_nettype wire

// file: acr_div_if.sv
`timescale 1ns/100ps
`default_nettype none

// prescale select going out, internal converter tick coming back
interface acr_div_if;
    logic [2:0] prescale;
    logic tick;
    modport ctrl (output prescale, input tick);
    modport div (input prescale, output tick);
endinterface

`default_nettype wire

// file: acr_sync3.sv
`timescale 1ns/100ps
`default_nettype none

module acr_sync3 (
    // clock and reset
    input wire logic clk,
    input wire logic rst_sync_n,
    input wire logic ce,
    // signal
    input wire logic async_in,
    output logic sync_out
);
    logic q1;
    logic q2;
    logic q3;

    // three stages; the output moves only once stages two and three agree
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            q1 <= 1'b0;
            q2 <= 1'b0;
            q3 <= 1'b0;
            sync_out <= 1'b0;
        end else if (ce) begin
            q1 <= async_in;
            q2 <= q1;
            q3 <= q2;
            if (q2 == q3) begin
                sync_out <= q3;
            end
        end
    end

    a_sync_agree: assert property (@(posedge clk) disable iff (!rst_sync_n)
        (ce && q2 == q3) |=> (sync_out == $past(q3)))
        else $error("synchroniser output missed an agreed level");
endmodule

`default_nettype wire

// file: acr_prescaler.sv
`timescale 1ns/100ps
`default_nettype none

module acr_prescaler import acr_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rst_sync_n,
    input wire logic ce,
    // select and tick
    acr_div_if.div div_bus
);
    logic [3:0] cnt;
    logic [3:0] limit;

    always_comb begin
        case (div_bus.prescale)
            3'h0: limit = DIV1_LIMIT;
            3'h1: limit = DIV2_LIMIT;
            3'h2: limit = DIV4_LIMIT;
            3'h3: limit = DIV8_LIMIT;
            default: limit = DIV16_LIMIT;
        endcase
    end

    // compare with >= so a smaller ratio chosen mid-count ticks at once
    assign div_bus.tick = (cnt >= limit);

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            cnt <= 4'h0;
        end else if (ce) begin
            cnt <= div_bus.tick ? 4'h0 : cnt + 4'h1;
        end
    end

    a_div_two: assert property (@(posedge clk) disable iff (!rst_sync_n)
        (ce && div_bus.tick && div_bus.prescale == 3'h1)
        ##1 (ce && div_bus.prescale == 3'h1) [*2]
        |-> (div_bus.tick && !$past(div_bus.tick)))
        else $error("divide by two tick spacing wrong");

    a_div_sixteen: assert property (@(posedge clk) disable iff (!rst_sync_n)
        (ce && div_bus.tick && div_bus.prescale[2]) ##1 (ce && div_bus.prescale[2])
        ##1 div_bus.prescale[2]
        |-> (!div_bus.tick && cnt == 4'h1))
        else $error("divide by sixteen restarted early");
endmodule

`default_nettype wire

// file: acr_adc_control.sv
`timescale 1ns/100ps
`default_nettype none

module acr_adc_control import acr_pkg::*; (
    // clock, reset, enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rd_data,
    // interrupt
    output logic irq,
    // analog front end
    input wire logic comp_high,
    output logic [4:0] mux_select,
    output logic power_off,
    output logic sample_hold,
    output logic [7:0] dac_code
);

    // ****************************************************************
    // declarations
    // ****************************************************************
    logic rst_q1;
    logic rst_ok;
    logic comp_sync;
    logic irq_en;
    logic continuous;
    logic flag;
    logic conv_pending;
    logic [2:0] prescale;
    logic [7:0] result;
    logic evt_status;
    logic evt_enable;
    acr_state_t state;
    acr_state_t next_state;
    logic [3:0] bit_cnt;
    logic [3:0] next_cnt;
    logic [2:0] trial_bit;
    logic [7:0] next_code;
    logic [7:0] read_value;
    logic wr_scr;
    logic wr_div;
    logic wr_clr;
    logic wr_en;
    logic rd_result;
    logic wr_off;
    logic tick;
    logic conv_done;
    logic set_flag;
    logic set_pending;
    logic clr_flag;

    acr_div_if div_bus ();

    // ****************************************************************
    // reset release and input synchroniser
    // ****************************************************************

    // release through two stages so every flop leaves reset on one edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_q1 <= 1'b0;
            rst_ok <= 1'b0;
        end else if (ce) begin
            rst_q1 <= 1'b1;
            rst_ok <= rst_q1;
        end
    end

    acr_sync3 u_comp_sync (
        .clk(clk),
        .rst_sync_n(rst_ok),
        .ce(ce),
        .async_in(comp_high),
        .sync_out(comp_sync)
    );

    // internal converter clock from the prescaler
    assign div_bus.prescale = prescale;
    assign tick = div_bus.tick;

    acr_prescaler u_prescaler (
        .clk(clk),
        .rst_sync_n(rst_ok),
        .ce(ce),
        .div_bus(div_bus)
    );

    // ****************************************************************
    // register decode
    // ****************************************************************
    assign wr_scr = wr && (addr == SCR_ADDR);
    assign wr_div = wr && (addr == DIVIDER_ADDR);
    assign wr_clr = wr && (addr == EVT_CLEAR_ADDR);
    assign wr_en = wr && (addr == EVT_ENABLE_ADDR);
    assign rd_result = rd && (addr == RESULT_ADDR);
    assign wr_off = (wr_data[CHAN_LSB +: CHAN_W] == CHAN_POWER_OFF);

    // last of sixteen converter clocks inside a conversion
    assign conv_done = (state == ST_CONV) && tick && (bit_cnt == CONV_LAST);

    // ****************************************************************
    // control fields
    // ****************************************************************

    // reset leaves single mode with interrupts off
    always_ff @(posedge clk or negedge rst_ok) begin
        if (!rst_ok) begin
            irq_en <= SCR_RESET[IRQEN_BIT];
            continuous <= SCR_RESET[CONT_BIT];
        end else if (ce && wr_scr) begin
            irq_en <= wr_data[IRQEN_BIT];
            continuous <= wr_data[CONT_BIT];
        end
    end

    // channel code drives the analog mux directly
    always_ff @(posedge clk or negedge rst_ok) begin
        if (!rst_ok) begin
            mux_select <= SCR_RESET[CHAN_LSB +: CHAN_W];
        end else if (ce && wr_scr) begin
            mux_select <= wr_data[CHAN_LSB +: CHAN_W];
        end
    end

    // all-ones code switches the analog part off
    always_ff @(posedge clk or negedge rst_ok) begin
        if (!rst_ok) begin
            power_off <= (SCR_RESET[CHAN_LSB +: CHAN_W] == CHAN_POWER_OFF);
        end else if (ce && wr_scr) begin
            power_off <= wr_off;
        end
    end

    // prescale select, low five bits are not stored
    always_ff @(posedge clk or negedge rst_ok) begin
        if (!rst_ok) begin
            prescale <= DIVIDER_RESET[PRESCALE_LSB +: PRESCALE_W];
        end else if (ce && wr_div) begin
            prescale <= wr_data[PRESCALE_LSB +: PRESCALE_W];
        end
    end

    // ****************************************************************
    // conversion sequencer
    // ****************************************************************

    // a write while converting aborts and rearms, or goes idle for the power-off code, so software never
    // sees a result built from two channels
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                // a control write with any code but power off arms a start
                if (wr_scr && !wr_off) begin
                    next_state = ST_ARMED;
                end
            end
            ST_ARMED: begin
                if (wr_scr) begin
                    next_state = wr_off ? ST_IDLE : ST_ARMED;
                end else if (tick) begin
                    next_state = ST_CONV;
                end
            end
            ST_CONV: begin
                if (wr_scr) begin
                    next_state = wr_off ? ST_IDLE : ST_ARMED;
                end else if (conv_done) begin
                    // single mode stops after one result
                    next_state = continuous ? ST_CONV : ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_ok) begin
        if (!rst_ok) begin
            state <= ST_IDLE;
        end else if (ce) begin
            state <= next_state;
        end
    end

    // step counter, wraps from fifteen to zero on restart
    always_comb begin
        if (next_state != ST_CONV) begin
            next_cnt = 4'h0;
        end else if (state == ST_CONV && tick) begin
            next_cnt = bit_cnt + 4'h1;
        end else begin
            next_cnt = bit_cnt;
        end
    end

    always_ff @(posedge clk or negedge rst_ok) begin
        if (!rst_ok) begin
            bit_cnt <= 4'h0;
            sample_hold <= 1'b0;
        end else if (ce) begin
            bit_cnt <= next_cnt;
            sample_hold <= (next_state == ST_CONV) && (next_cnt <= SAMPLE_LAST);
        end
    end

    // ****************************************************************
    // successive approximation
    // ****************************************************************

    // the comparator answer lags the dac by about four system clocks;
    // slow prescale settings leave it time to settle
    always_comb begin
        trial_bit = 3'(CONV_LAST - bit_cnt);
        next_code = dac_code;
        next_code[trial_bit] = comp_sync;
        if (trial_bit != 3'h0) begin
            next_code[trial_bit - 3'h1] = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_ok) begin
        if (!rst_ok) begin
            dac_code <= 8'h00;
        end else if (ce && state == ST_CONV && tick && !wr_scr) begin
            if (bit_cnt == SAMPLE_LAST) begin
                dac_code <= DAC_FIRST_TRIAL;
            end else if (bit_cnt > SAMPLE_LAST) begin
                dac_code <= next_code;
            end
        end
    end

    // load result at every conversion end
    // no check for an unread previous value
    // unused codes are converted as is, no fixup
    always_ff @(posedge clk or negedge rst_ok) begin
        if (!rst_ok) begin
            result <= RESULT_RESET;
        end else if (ce && conv_done && !wr_scr) begin
            result <= next_code;
        end
    end

    // ****************************************************************
    // completion flag and interrupt
    // ****************************************************************
    assign set_flag = conv_done && !wr_scr && !irq_en;
    assign set_pending = conv_done && !wr_scr && irq_en;
    assign clr_flag = wr_scr || rd_result;

    // flag set only with interrupts off
    // write, result read and reset clear; a set wins over a clear
    always_ff @(posedge clk or negedge rst_ok) begin
        if (!rst_ok) begin
            flag <= SCR_RESET[FLAG_BIT];
        end else if (ce) begin
            if (set_flag) begin
                flag <= 1'b1;
            end else if (clr_flag) begin
                flag <= 1'b0;
            end
        end
    end

    // request raised at each end with interrupts on
    // dropped by result read or control write
    always_ff @(posedge clk or negedge rst_ok) begin
        if (!rst_ok) begin
            conv_pending <= 1'b0;
        end else if (ce) begin
            if (set_pending) begin
                conv_pending <= 1'b1;
            end else if (clr_flag) begin
                conv_pending <= 1'b0;
            end
        end
    end

    // sticky event status, cleared by writing one; set wins
    always_ff @(posedge clk or negedge rst_ok) begin
        if (!rst_ok) begin
            evt_status <= EVT_RESET[EVT_DONE_BIT];
            evt_enable <= EVT_RESET[EVT_DONE_BIT];
        end else if (ce) begin
            if (conv_done && !wr_scr) begin
                evt_status <= 1'b1;
            end else if (wr_clr && wr_data[EVT_DONE_BIT]) begin
                evt_status <= 1'b0;
            end
            if (wr_en) begin
                evt_enable <= wr_data[EVT_DONE_BIT];
            end
        end
    end

    // one output for both sources, a cycle behind the flags
    always_ff @(posedge clk or negedge rst_ok) begin
        if (!rst_ok) begin
            irq <= 1'b0;
        end else if (ce) begin
            irq <= conv_pending || (evt_status && evt_enable);
        end
    end

    // ****************************************************************
    // read port
    // ****************************************************************
    always_comb begin
        case (addr)
            // flag hidden while interrupts are on
            SCR_ADDR: read_value = {flag && !irq_en, irq_en, continuous, mux_select};
            RESULT_ADDR: read_value = result;
            DIVIDER_ADDR: read_value = {prescale, 5'h00};
            EVT_STATUS_ADDR: read_value = {7'h00, evt_status};
            EVT_ENABLE_ADDR: read_value = {7'h00, evt_enable};
            default: read_value = 8'h00;
        endcase
    end

    // data stand only in the cycle after the strobe
    always_ff @(posedge clk or negedge rst_ok) begin
        if (!rst_ok) begin
            rd_data <= 8'h00;
        end else if (ce) begin
            rd_data <= rd ? read_value : 8'h00;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    a_flag_set: assert property (@(posedge clk) disable iff (!rst_ok)
        (ce && set_flag) |=> flag)
        else $error("completion flag not set at conversion end");

    a_flag_clear: assert property (@(posedge clk) disable iff (!rst_ok)
        (ce && clr_flag && !set_flag) |=> !flag)
        else $error("completion flag survived a clear");

    a_flag_hidden: assert property (@(posedge clk) disable iff (!rst_ok)
        (ce && rd && addr == SCR_ADDR && irq_en) |=> !rd_data[FLAG_BIT])
        else $error("completion flag visible with interrupts on");

    a_irq_raise: assert property (@(posedge clk) disable iff (!rst_ok)
        (ce && set_pending) ##1 ce |=> irq)
        else $error("interrupt not raised at conversion end");

    a_irq_drop: assert property (@(posedge clk) disable iff (!rst_ok)
        (ce && rd_result && !set_pending) |=> !conv_pending)
        else $error("pending request kept after result read");

    a_cont_repeat: assert property (@(posedge clk) disable iff (!rst_ok)
        (ce && conv_done && continuous && !wr_scr) |=> (state == ST_CONV && bit_cnt == 4'h0))
        else $error("continuous mode did not restart");

    a_single_stop: assert property (@(posedge clk) disable iff (!rst_ok)
        (ce && conv_done && !continuous && !wr_scr) |=> (state == ST_IDLE))
        else $error("single mode kept converting");

    a_reset_mode: assert property (@(posedge clk)
        $rose(rst_ok) |-> (!irq_en && !continuous && power_off))
        else $error("reset mode wrong");

    a_start_tick: assert property (@(posedge clk) disable iff (!rst_ok)
        (ce && state == ST_ARMED && tick && !wr_scr) |=> (state == ST_CONV && sample_hold))
        else $error("conversion did not start on tick");

    a_result_load: assert property (@(posedge clk) disable iff (!rst_ok)
        (ce && conv_done && !wr_scr) |=> (result == $past(next_code)))
        else $error("result not loaded");

    a_result_hold: assert property (@(posedge clk) disable iff (!rst_ok)
        !(ce && conv_done) |=> $stable(result))
        else $error("result changed between conversions");

    a_power_code: assert property (@(posedge clk) disable iff (!rst_ok)
        (ce && wr_scr) |=> (power_off == (mux_select == CHAN_POWER_OFF)))
        else $error("power off does not follow channel code");
endmodule

`default_nettype wire

// file: acr_adc_control_tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module acr_adc_control_tb_top import acr_pkg::*; ;
    // ****************************************************************
    // bench state
    // ****************************************************************
    logic clk, rst_n, ce, wr, rd, comp_high, irq, power_off, sample_hold, rd_seen;
    logic [7:0] addr, wr_data, rd_data, last_rd, dac_code;
    logic [4:0] mux_select;
    logic [8:0] exp_q[$];
    logic [4:0] codes [9] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h1b, 5'h1d, 5'h1e};
    int err_total, cmp_count, cycles, pre;
    bit c;

    acr_adc_control u_acr_adc_control (.clk(clk), .rst_n(rst_n), .ce(ce), .addr(addr),
        .wr_data(wr_data), .wr(wr), .rd(rd), .rd_data(rd_data), .irq(irq),
        .comp_high(comp_high), .mux_select(mux_select), .power_off(power_off),
        .sample_hold(sample_hold), .dac_code(dac_code));

    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wr_data <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // bit 8 of a note marks a poll whose answer is not compared
    task automatic rd_reg(input logic [7:0] a, input logic [8:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
        #1 last_rd = rd_data;
    endtask

    // polling reads of the control register leave the flag alone
    task automatic wait_flag();
        int n;
        n = 0;
        last_rd = 8'h00;
        while (last_rd[FLAG_BIT] !== 1'b1 && n < 300) begin
            rd_reg(SCR_ADDR, 9'h100);
            n++;
        end
        chk8({7'h00, last_rd[FLAG_BIT]}, 8'h01);
    endtask

    // scoreboard: answer stands only in the cycle after the strobe
    always @(posedge clk) begin
        if (rd_seen && exp_q.size() > 0) begin
            if (exp_q[0][8] === 1'b0) begin
                chk8(rd_data, exp_q[0][7:0]);
            end
            void'(exp_q.pop_front());
        end
        rd_seen = rd;
    end

    // hang guard, well above the longest expected run
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            report_and_stop();
        end
    end

    initial begin
        {ce, rst_n, wr, rd, comp_high, rd_seen} = 6'b100000;
        {addr, wr_data, last_rd} = '0;
        {err_total, cmp_count, cycles} = '0;
        void'($urandom(39852));
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd_reg(SCR_ADDR, {1'b0, SCR_RESET});
        rd_reg(DIVIDER_ADDR, 9'h000);
        rd_reg(8'h50, 9'h000);
        rd_reg(EVT_ENABLE_ADDR, 9'h000);
        chk8({7'h00, power_off}, 8'h01);
        foreach (codes[i]) begin
            wr_reg(SCR_ADDR, {3'h0, codes[i]});
            #1;
            chk8({3'h0, mux_select}, {3'h0, codes[i]});
            chk8({7'h00, power_off}, 8'h00);
        end
        // divide by two long enough for its tick spacing check
        wr_reg(DIVIDER_ADDR, 8'h20);
        rd_reg(DIVIDER_ADDR, 9'h020);
        pre = 3 + $urandom % 5;
        wr_reg(DIVIDER_ADDR, {pre[2:0], 5'h00});
        rd_reg(DIVIDER_ADDR, {1'b0, pre[2:0], 5'h00});
        @(posedge clk);
        c = 1'($urandom % 2);
        comp_high <= c;
        wr_reg(SCR_ADDR, 8'h02);
        wait_flag();
        rd_reg(RESULT_ADDR, {1'b0, {8{c}}});
        chk8(dac_code, {8{c}});
        rd_reg(SCR_ADDR, 9'h002);
        repeat (600) @(posedge clk);
        rd_reg(SCR_ADDR, 9'h002);
        chk8({7'h00, sample_hold}, 8'h00);
        wr_reg(SCR_ADDR, 8'h02);
        wait_flag();
        wr_reg(SCR_ADDR, 8'h03);
        rd_reg(SCR_ADDR, 9'h003);
        wr_reg(SCR_ADDR, 8'hc2);
        rd_reg(SCR_ADDR, 9'h042);
        while (irq !== 1'b1 && cycles < 19000) @(posedge clk);
        rd_reg(SCR_ADDR, 9'h042);
        chk8({7'h00, irq}, 8'h01);
        rd_reg(RESULT_ADDR, {1'b0, {8{c}}});
        // irq is registered, so it drops one edge after the request
        @(posedge clk);
        #1;
        chk8({7'h00, irq}, 8'h00);
        wr_reg(SCR_ADDR, 8'h22);
        wait_flag();
        chk8({7'h00, sample_hold}, 8'h01);
        @(posedge clk);
        comp_high <= ~c;
        rd_reg(RESULT_ADDR, 9'h100);
        wait_flag();
        rd_reg(RESULT_ADDR, 9'h100);
        wait_flag();
        rd_reg(RESULT_ADDR, {1'b0, {8{~c}}});
        wr_reg(SCR_ADDR, 8'h1f);
        #1;
        chk8({7'h00, power_off}, 8'h01);
        wr_reg(RESULT_ADDR, {8{c}});
        rd_reg(RESULT_ADDR, {1'b0, {8{~c}}});
        rd_reg(EVT_STATUS_ADDR, 9'h001);
        wr_reg(EVT_ENABLE_ADDR, 8'h01);
        rd_reg(EVT_ENABLE_ADDR, 9'h001);
        chk8({7'h00, irq}, 8'h01);
        wr_reg(EVT_CLEAR_ADDR, 8'h01);
        rd_reg(EVT_CLEAR_ADDR, 9'h000);
        rd_reg(EVT_STATUS_ADDR, 9'h000);
        chk8({7'h00, irq}, 8'h00);
        report_and_stop();
    end
endmodule

`default_nettype wire
